//--- logic/bie_cfg.svh
// Purpose: Offsets, field positions, reset values and masks of the block
//          interrupt enable logic.
// Assumes: Included by the package and the design modules by its bare name.
// Notes:   Definitions only.
`ifndef BIE_CFG_SVH
`define BIE_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define BIE_OFS_ENABLE  12'h000
`define BIE_OFS_STATUS  12'h004

// ****************************************************************
// Field layout
// ****************************************************************
`define BIE_NBLK        8
`define BIE_BIT_NATBIT  7
`define BIE_BIT_RSVD    6
`define BIE_BIT_CLKLOSS 5
`define BIE_BIT_ONESEC  4
`define BIE_BIT_LINKCTL 3
`define BIE_BIT_SLIP    2
`define BIE_BIT_ALARM   1
`define BIE_BIT_FRAMER  0

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define BIE_EN_RESET    8'h00
`define BIE_ST_RESET    1'h0
`define BIE_IRQ_N_IDLE  1'h1
`define BIE_LIVE_MASK   8'hbf
`define BIE_WORD_ZERO   32'h0000_0000
`define BIE_PAD_ZERO    24'h00_0000

`endif

//--- logic/bie_pkg.sv
// Purpose: Shared types of the block interrupt enable logic.
// Assumes: bie_cfg.svh is on the include path.
// Notes:   Constants live in the header; only types live here.
`include "bie_cfg.svh"

package bie_pkg;

    typedef logic [`BIE_NBLK-1:0] bie_vec_t;
    typedef logic [31:0]          bie_word_t;

endpackage

//--- logic/bie_irq_cell.sv
// Purpose: One block's pending flag and its gated request.
// Assumes: Event and clear inputs are synchronous to pclk.
// Notes:   A reserved position never holds a pending flag.
`timescale 1ns/1ps
`include "bie_cfg.svh"

module bie_irq_cell #(
    parameter bit RSVD = 1'b0
) (
    input  wire logic pclk,      // register clock
    input  wire logic presetn,   // asynchronous reset, active low
    input  wire logic event_in,  // block raised a source-enabled request
    input  wire logic clear_in,  // block's own status register was read
    input  wire logic enable,    // block-level enable bit
    output logic      pending,   // pending flag of this block
    output logic      request    // pending flag gated by the enable
);

    logic pending_r;
    logic pending_nxt;

    // ****************************************************************
    // Pending flag
    // ****************************************************************
    // An event in the same cycle as the clearing read wins, so a new
    // request is never lost behind the read that services the old one.
    assign pending_nxt = RSVD ? `BIE_ST_RESET
                       : (event_in | (pending_r & ~clear_in));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= `BIE_ST_RESET;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    assign pending = pending_r;
    // A cleared enable blocks every source of the block.
    assign request = pending_r & enable;

endmodule

//--- logic/bie_block_irq_enable.sv
// Purpose: Block-level interrupt enable and status with an APB slave port.
// Assumes: Block event and status-read strobes are synchronous to pclk;
//          each block already applies its own source-level enables.
// Notes:   Zero wait-state slave; read data is captured in the setup cycle.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "bie_cfg.svh"

// Summary of operation
// - Bit 7 of the enable register is a read/write national-bit block enable, zero after reset.
// - While the national-bit enable is zero, nothing from that block reaches the interrupt output.
// - Setting an enable alone raises nothing; a request appears only when a source-enabled event is pending.
// - Bit 5 is a read/write enable for the recovered-clock loss interrupt, zero after reset.
// - Bit 4 is a read/write enable for the one-second tick interrupt, zero after reset.
// - Bit 3 is a read/write link controller block enable, zero after reset.
// - With the link controller enable cleared, none of its sources reach the interrupt output.
// - Bit 2 is a read/write slip buffer block enable, zero after reset.
// - With the slip buffer enable cleared, none of its sources raise an interrupt.
// - Bit 1 is a read/write alarm and error block enable, zero after reset, which blocks that block when cleared.
// - Bit 0 is a read/write framer block enable, zero after reset, which blocks that block when cleared.
// - Each block status bit reads one while that block has a request pending and zero otherwise.
// - A block status bit returns to zero once that block's own status register is read in a cycle with no new event from that block.
module bie_block_irq_enable #(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,            // register clock, 25 MHz
    input  wire logic              presetn,         // asynchronous reset, active low
    input  wire logic              psel,            // APB select
    input  wire logic              penable,         // APB access phase
    input  wire logic              pwrite,          // APB direction, high for write
    input  wire logic [ADDR_W-1:0] paddr,           // APB byte address
    input  wire logic [31:0]       pwdata,          // APB write data
    input  wire logic [3:0]        pstrb,           // APB byte strobes
    input  wire logic [7:0]        blk_event,       // per-block request pulse
    input  wire logic [7:0]        blk_status_read, // per-block status read pulse
    output logic [31:0]            prdata,          // APB read data
    output logic                   pready,          // APB ready
    output logic                   pslverr,         // APB error, unmapped address
    output logic                   irq_n            // interrupt pin, active low
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    bie_pkg::bie_vec_t  en_r;
    bie_pkg::bie_vec_t  en_nxt;
    bie_pkg::bie_vec_t  status_vec;
    bie_pkg::bie_vec_t  req_vec;
    bie_pkg::bie_vec_t  req_others;
    bie_pkg::bie_word_t prdata_r;
    bie_pkg::bie_word_t prdata_nxt;
    bie_pkg::bie_word_t rd_word;
    logic               pready_r;
    logic               pready_nxt;
    logic               pslverr_r;
    logic               pslverr_nxt;
    logic               irq_n_r;
    logic               irq_n_nxt;

    wire setup_ph;
    wire access_done;
    wire hit_enable;
    wire hit_status;
    wire hit_any;
    wire wr_enable;
    wire any_request;
    wire national_bit_block_irq_en;
    wire recovered_clock_loss_irq_en;
    wire one_second_irq_en;
    wire link_controller_block_irq_en;
    wire slip_buffer_irq_en;
    wire alarm_error_block_irq_en;
    wire framer_block_irq_en;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign setup_ph    = psel & ~penable;
    assign access_done = psel & penable & pready_r;
    assign hit_enable  = (paddr == ADDR_W'(`BIE_OFS_ENABLE));
    assign hit_status  = (paddr == ADDR_W'(`BIE_OFS_STATUS));
    assign hit_any     = hit_enable | hit_status;
    // Only byte lane 0 holds live bits, so its strobe gates the write.
    assign wr_enable   = access_done & pwrite & hit_enable & pstrb[0];

    // ****************************************************************
    // Enable register
    // ****************************************************************
    // Reserved position is masked on write so it always reads zero.
    assign en_nxt = wr_enable ? (pwdata[7:0] & `BIE_LIVE_MASK) : en_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= `BIE_EN_RESET;
        end else begin
            en_r <= en_nxt;
        end
    end

    // ****************************************************************
    // Enable fields
    // ****************************************************************
    // Named views of the live enable bits; the reserved position has none.
    // They are read by the per-block gate checks at the end of the file.
    assign national_bit_block_irq_en    = en_r[`BIE_BIT_NATBIT];
    assign recovered_clock_loss_irq_en  = en_r[`BIE_BIT_CLKLOSS];
    assign one_second_irq_en            = en_r[`BIE_BIT_ONESEC];
    assign link_controller_block_irq_en = en_r[`BIE_BIT_LINKCTL];
    assign slip_buffer_irq_en           = en_r[`BIE_BIT_SLIP];
    assign alarm_error_block_irq_en     = en_r[`BIE_BIT_ALARM];
    assign framer_block_irq_en          = en_r[`BIE_BIT_FRAMER];

    // ****************************************************************
    // Per-block pending flags and gating
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `BIE_NBLK; gi++) begin : g_blk
            bie_irq_cell #(
                .RSVD (gi == `BIE_BIT_RSVD)
            ) u_cell (
                .pclk     (pclk),
                .presetn  (presetn),
                .event_in (blk_event[gi]),
                .clear_in (blk_status_read[gi]),
                .enable   (en_r[gi]),
                .pending  (status_vec[gi]),
                .request  (req_vec[gi])
            );
            // Requests of every other block, so each gate can be checked alone.
            assign req_others[gi] = |(req_vec & ~(bie_pkg::bie_vec_t'(1) << gi));
        end
    endgenerate

    // ****************************************************************
    // Interrupt pin
    // ****************************************************************
    // Only a pending request can assert the pin, never an enable write alone.
    assign any_request = |req_vec;
    assign irq_n_nxt   = ~any_request;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_r <= `BIE_IRQ_N_IDLE;
        end else begin
            irq_n_r <= irq_n_nxt;
        end
    end

    // ****************************************************************
    // Read path and handshake
    // ****************************************************************
    // Data is sampled in the setup cycle; a status change in the access
    // cycle shows on the next read, a trade for registered outputs.
    assign rd_word = hit_enable ? {`BIE_PAD_ZERO, en_r}
                   : hit_status ? {`BIE_PAD_ZERO, status_vec}
                   : `BIE_WORD_ZERO;
    assign prdata_nxt  = (setup_ph & ~pwrite) ? rd_word : prdata_r;
    assign pready_nxt  = setup_ph;
    assign pslverr_nxt = setup_ph & ~hit_any;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= `BIE_WORD_ZERO;
            pready_r  <= `BIE_ST_RESET;
            pslverr_r <= `BIE_ST_RESET;
        end else begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq_n   = irq_n_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    bie_pkg::bie_vec_t live_evt;
    bie_pkg::bie_vec_t live_clr;
    assign live_evt = blk_event & `BIE_LIVE_MASK;
    assign live_clr = blk_status_read & ~blk_event & `BIE_LIVE_MASK;

    en_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && hit_enable && pstrb[0])
        |=> (en_r == ($past(pwdata[7:0]) & `BIE_LIVE_MASK)))
        else $error("enable register did not take the write");

    en_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable && pready && pwrite && hit_enable) |=> $stable(en_r))
        else $error("enable register changed without a write");

    rsvd_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (en_r[`BIE_BIT_RSVD] == 1'b0) && (status_vec[`BIE_BIT_RSVD] == 1'b0))
        else $error("reserved bit is not zero");

    gate_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((status_vec & en_r) == '0) |=> irq_n)
        else $error("interrupt asserted with no enabled pending block");

    irq_raise_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((status_vec & en_r) != '0) |=> !irq_n)
        else $error("interrupt missing for an enabled pending block");

    enable_alone_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (status_vec == '0 && live_evt == '0) |=> ##1 irq_n)
        else $error("enable alone raised the interrupt");

    status_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_evt != '0) |=> ((status_vec & $past(live_evt)) == $past(live_evt)))
        else $error("block event did not set its status bit");

    status_clr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_clr != '0) |=> ((status_vec & $past(live_clr)) == '0))
        else $error("status bit survived its clearing read");

    ready_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> (pready ##1 !pready))
        else $error("ready is not a single-cycle answer");

    rd_enable_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_enable)
        |=> (prdata == {`BIE_PAD_ZERO, $past(en_r)}))
        else $error("enable register read back wrong");

    rd_status_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_status)
        |=> (prdata == {`BIE_PAD_ZERO, $past(status_vec)}))
        else $error("status register read back wrong");

    status_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_evt == '0 && live_clr == '0) |=> $stable(status_vec))
        else $error("status changed with no event and no clearing read");

    status_only_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (live_clr == '0) |=> ((status_vec & $past(status_vec)) == $past(status_vec)))
        else $error("status bit fell without its clearing read");

    // ****************************************************************
    // Per-block gate checks
    // ****************************************************************
    // Each gate is checked on the pin with every other block quiet, so a
    // broken gate cannot hide behind another block's request.
    natbit_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!national_bit_block_irq_en && !req_others[`BIE_BIT_NATBIT]) |=> irq_n)
        else $error("national-bit block reached the pin while disabled");

    natbit_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (national_bit_block_irq_en && status_vec[`BIE_BIT_NATBIT]) |=> !irq_n)
        else $error("enabled national-bit block did not reach the pin");

    clkloss_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!recovered_clock_loss_irq_en && !req_others[`BIE_BIT_CLKLOSS]) |=> irq_n)
        else $error("clock loss reached the pin while disabled");

    clkloss_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (recovered_clock_loss_irq_en && status_vec[`BIE_BIT_CLKLOSS]) |=> !irq_n)
        else $error("enabled clock loss did not reach the pin");

    tick_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!one_second_irq_en && !req_others[`BIE_BIT_ONESEC]) |=> irq_n)
        else $error("one-second tick reached the pin while disabled");

    tick_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (one_second_irq_en && status_vec[`BIE_BIT_ONESEC]) |=> !irq_n)
        else $error("enabled one-second tick did not reach the pin");

    linkctl_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!link_controller_block_irq_en && !req_others[`BIE_BIT_LINKCTL]) |=> irq_n)
        else $error("link controller block reached the pin while disabled");

    linkctl_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (link_controller_block_irq_en && status_vec[`BIE_BIT_LINKCTL]) |=> !irq_n)
        else $error("enabled link controller block did not reach the pin");

    slip_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!slip_buffer_irq_en && !req_others[`BIE_BIT_SLIP]) |=> irq_n)
        else $error("slip buffer block reached the pin while disabled");

    slip_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (slip_buffer_irq_en && status_vec[`BIE_BIT_SLIP]) |=> !irq_n)
        else $error("enabled slip buffer block did not reach the pin");

    alarm_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!alarm_error_block_irq_en && !req_others[`BIE_BIT_ALARM]) |=> irq_n)
        else $error("alarm and error block reached the pin while disabled");

    alarm_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (alarm_error_block_irq_en && status_vec[`BIE_BIT_ALARM]) |=> !irq_n)
        else $error("enabled alarm and error block did not reach the pin");

    framer_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!framer_block_irq_en && !req_others[`BIE_BIT_FRAMER]) |=> irq_n)
        else $error("framer block reached the pin while disabled");

    framer_pass_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (framer_block_irq_en && status_vec[`BIE_BIT_FRAMER]) |=> !irq_n)
        else $error("enabled framer block did not reach the pin");

endmodule

//--- tb/test_bie_block_irq_enable.sv
// Purpose: Self-checking bench for the block interrupt enable logic.
// Assumes: Zero wait-state APB slave; irq_n follows status and enable one cycle late.
// Notes:   Ordinary cases run from a table; reset and odd cases follow by hand.
`timescale 1ns/1ps
`include "bie_cfg.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module test_bie_block_irq_enable;

    // ************************************************************
    // Signals and design
    // ************************************************************
    typedef struct packed {
        logic [7:0] en_w;
        logic [7:0] ev;
        logic [7:0] en_exp;
        logic       irq_n_exp;
    } bie_row_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [7:0]  blk_event = 8'h00;
    logic [7:0]  blk_status_read = 8'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_n;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          n_checks = 0;
    bie_row_t    rows [14];

    always #20 pclk = ~pclk;

    bie_block_irq_enable #(.ADDR_W(12)) bie_block_irq_enable_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .blk_event(blk_event),
        .blk_status_read(blk_status_read), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_n(irq_n));

    // ************************************************************
    // Tasks
    // ************************************************************
    // The leading edge keeps a new setup from landing in the step that released the last one.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [7:0] ev, input logic [7:0] clr);
        @(posedge pclk);
        blk_event <= ev;
        blk_status_read <= clr;
        @(posedge pclk);
        blk_event <= 8'h00;
        blk_status_read <= 8'h00;
        repeat (3) @(posedge pclk);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        final_report();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rows = '{
            '{8'h80, 8'h80, 8'h80, 1'b0},
            '{8'h7f, 8'h80, 8'h3f, 1'b1},
            '{8'h20, 8'h20, 8'h20, 1'b0},
            '{8'h10, 8'h10, 8'h10, 1'b0},
            '{8'h08, 8'h08, 8'h08, 1'b0},
            '{8'hf7, 8'h08, 8'hb7, 1'b1},
            '{8'h04, 8'h04, 8'h04, 1'b0},
            '{8'hfb, 8'h04, 8'hbb, 1'b1},
            '{8'h02, 8'h02, 8'h02, 1'b0},
            '{8'hfd, 8'h02, 8'hbd, 1'b1},
            '{8'h01, 8'h01, 8'h01, 1'b0},
            '{8'hfe, 8'h01, 8'hbe, 1'b1},
            '{8'h40, 8'h40, 8'h00, 1'b1},
            '{8'hff, 8'h00, 8'hbf, 1'b1}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(irq_n, 1'b1)
        apb(1'b0, `BIE_OFS_ENABLE, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        foreach (rows[i]) begin
            apb(1'b1, `BIE_OFS_ENABLE, {24'h00_0000, rows[i].en_w}, 4'hf);
            apb(1'b0, `BIE_OFS_ENABLE, 32'h0, 4'hf);
            `CHK(rd, {24'h00_0000, rows[i].en_exp})
            pulse(rows[i].ev, 8'h00);
            `CHK(irq_n, rows[i].irq_n_exp)
            apb(1'b0, `BIE_OFS_STATUS, 32'h0, 4'hf);
            `CHK(rd, {24'h00_0000, rows[i].ev & 8'hbf})
            pulse(8'h00, rows[i].ev);
            `CHK(irq_n, 1'b1)
            apb(1'b0, `BIE_OFS_STATUS, 32'h0, 4'hf);
            `CHK(rd, 32'h0000_0000)
        end
        // Writes without the low strobe and to the status word, then a read of an unmapped word.
        apb(1'b1, `BIE_OFS_ENABLE, 32'h0, 4'he);
        apb(1'b1, `BIE_OFS_STATUS, 32'hff, 4'hf);
        apb(1'b0, `BIE_OFS_STATUS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h008, 32'h0, 4'hf);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        apb(1'b0, `BIE_OFS_ENABLE, 32'h0, 4'hf);
        `CHK({err, rd}, {1'b0, 32'h0000_00bf})
        // Event and clear in the same cycle: the event must stay pending.
        pulse(8'h04, 8'h04);
        `CHK(irq_n, 1'b0)
        // Reset in mid-run clears the enables and returns the pin high.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(irq_n, 1'b1)
        apb(1'b0, `BIE_OFS_ENABLE, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, `BIE_OFS_STATUS, 32'h0, 4'hf);
        `CHK(rd, 32'h0000_0000)
        final_report();
    end

endmodule
